// File: logic/dmach_channel.sv
// one memory-mapped dma channel with its AHB-Lite register slave
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "dmach_map.svh"

module dmach_channel #(
	parameter logic [2:0] CHANNEL_NUM = 3'h0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// AHB-Lite register slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// bus arbitration toward the channel arbiter
	output logic busReq,
	input wire logic busGrant,
	output logic busLock,
	output logic [2:0] chanPriority,
	output logic [2:0] chanNumber,
	// system bus master port
	output logic memReq,
	output logic memWrite,
	output logic [31:0] memAddr,
	output logic [1:0] memSize,
	output logic [31:0] memWdata,
	input wire logic [31:0] memRdata,
	input wire logic memReady,
	// peripheral request and status
	input wire logic periphReq,
	output logic chanIrq,
	output logic chanActive
);

	dmach_pkg::dmach_state_t stateQ;
	dmach_pkg::dmach_half_t srcLowQ;
	dmach_pkg::dmach_half_t srcHighQ;
	dmach_pkg::dmach_half_t dstLowQ;
	dmach_pkg::dmach_half_t dstHighQ;
	dmach_pkg::dmach_half_t thrQ;
	dmach_pkg::dmach_half_t lenQ;
	dmach_pkg::dmach_half_t ctrlQ;
	dmach_pkg::dmach_half_t idxQ;
	dmach_pkg::dmach_half_t idxNext;
	logic wrPendQ;
	logic [29:0] wrIdxQ;
	logic [31:0] dataQ;
	logic reqS1Q;
	logic reqS2Q;
	logic reqS3Q;
	logic edgePendQ;
	logic reqSeen;
	logic reqTake;
	logic addrPhase;
	logic ctrlWrite;
	logic itemDone;
	logic lastItem;
	logic finish;
	logic keepOn;
	logic chanOn;
	logic fillMode;
	logic reqMode;
	logic yieldMode;
	logic [31:0] srcStart;
	logic [31:0] dstStart;
	logic [31:0] srcCur;
	logic [31:0] dstCur;
	logic [31:0] srcNext;
	logic [31:0] dstNext;

	// address of item n: start plus n scaled by width when stepping
	function automatic logic [31:0] itemAddr(
		input logic [31:0] start,
		input logic step,
		input logic [1:0] width,
		input logic [15:0] n
	);
		logic [31:0] off;
		off = {16'h0000, n};
		if (!step) begin
			itemAddr = start;
		end else begin
			case (width)
				2'h1: itemAddr = start + {off[30:0], 1'b0};
				2'h2: itemAddr = start + {off[29:0], 2'b00};
				default: itemAddr = start + off;
			endcase
		end
	endfunction

	// control fields
	assign chanOn = ctrlQ[`DMACH_ON];
	assign fillMode = ctrlQ[`DMACH_FILL];
	assign reqMode = ctrlQ[`DMACH_REQMODE];
	assign yieldMode = ctrlQ[`DMACH_YIELD];
	assign srcStart = {srcHighQ, srcLowQ};
	assign dstStart = {dstHighQ, dstLowQ};

	// current and next item addresses
	assign idxNext = idxQ + 16'h0001;
	assign srcCur = itemAddr(srcStart, ctrlQ[`DMACH_SINC],
		ctrlQ[`DMACH_BW_HI:`DMACH_BW_LO], idxQ);
	assign dstCur = itemAddr(dstStart, ctrlQ[`DMACH_DINC],
		ctrlQ[`DMACH_BW_HI:`DMACH_BW_LO], idxQ);
	assign srcNext = itemAddr(srcStart, ctrlQ[`DMACH_SINC],
		ctrlQ[`DMACH_BW_HI:`DMACH_BW_LO], idxNext);
	assign dstNext = itemAddr(dstStart, ctrlQ[`DMACH_DINC],
		ctrlQ[`DMACH_BW_HI:`DMACH_BW_LO], idxNext);

	// item and transfer completion
	assign itemDone = (stateQ == dmach_pkg::ST_WRITE) && memReady;
	assign lastItem = (idxQ == lenQ);
	assign finish = itemDone && lastItem;
	assign keepOn = ctrlQ[`DMACH_CIRC] && reqMode;

	// bus slave always ready, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addrPhase = hsel && htrans[1] && hready;
	// only the low 30 bits of an index fit the word address
	assign ctrlWrite = wrPendQ && (wrIdxQ == 30'(`DMACH_IDX_CTRL));

	// request sensing: level or pending rising edge
	assign reqSeen = ctrlQ[`DMACH_SENSE] ? edgePendQ : reqS2Q;
	assign reqTake = (stateQ == dmach_pkg::ST_IDLE) && chanOn &&
		reqMode && reqSeen;

	// arbitration outputs
	assign busReq = (stateQ != dmach_pkg::ST_IDLE) &&
		(stateQ != dmach_pkg::ST_GAP) && chanOn;
	assign chanPriority = ctrlQ[`DMACH_PRIO_HI:`DMACH_PRIO_LO];
	assign chanNumber = CHANNEL_NUM;
	// fill holds every channel off; blocking holds lower masters off
	assign busLock = busReq &&
		(fillMode || (!yieldMode && !reqMode));
	assign memReq = (stateQ == dmach_pkg::ST_READ) ||
		(stateQ == dmach_pkg::ST_WRITE);
	assign chanActive = (stateQ != dmach_pkg::ST_IDLE);

	// peripheral request synchroniser and edge stage
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			reqS1Q <= 1'b0;
			reqS2Q <= 1'b0;
			reqS3Q <= 1'b0;
		end else begin
			reqS1Q <= periphReq;
			reqS2Q <= reqS1Q;
			reqS3Q <= reqS2Q;
		end
	end

	// pending rising edge; a new edge wins over its consumption
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			edgePendQ <= 1'b0;
		end else if (reqS2Q && !reqS3Q) begin
			edgePendQ <= 1'b1;
		end else if (reqTake || !chanOn) begin
			edgePendQ <= 1'b0;
		end
	end

	// write data phase bookkeeping
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPendQ <= 1'b0;
			wrIdxQ <= 30'h00000000;
		end else begin
			wrPendQ <= addrPhase && hwrite;
			if (addrPhase) begin
				wrIdxQ <= haddr[31:2];
			end
		end
	end

	// read data registered in the address phase
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			hrdata <= `DMACH_RST32;
		end else if (addrPhase && !hwrite) begin
			case (haddr[31:2])
				30'(`DMACH_IDX_ITEM): hrdata <= {16'h0000, idxQ};
				30'(`DMACH_IDX_SRCL): hrdata <= {16'h0000, srcLowQ};
				30'(`DMACH_IDX_SRCH): hrdata <= {16'h0000, srcHighQ};
				30'(`DMACH_IDX_DSTL): hrdata <= {16'h0000, dstLowQ};
				30'(`DMACH_IDX_DSTH): hrdata <= {16'h0000, dstHighQ};
				30'(`DMACH_IDX_THR): hrdata <= {16'h0000, thrQ};
				30'(`DMACH_IDX_LEN): hrdata <= {16'h0000, lenQ};
				30'(`DMACH_IDX_CTRL): hrdata <= {16'h0000, ctrlQ};
				default: hrdata <= `DMACH_RST32;
			endcase
		end
	end

	// plain read-write registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			srcLowQ <= `DMACH_RST16;
			srcHighQ <= `DMACH_RST16;
			dstLowQ <= `DMACH_RST16;
			dstHighQ <= `DMACH_RST16;
			thrQ <= `DMACH_RST16;
			lenQ <= `DMACH_RST16;
		end else if (wrPendQ) begin
			case (wrIdxQ)
				30'(`DMACH_IDX_SRCL): srcLowQ <= hwdata[15:0];
				30'(`DMACH_IDX_SRCH): srcHighQ <= hwdata[15:0];
				30'(`DMACH_IDX_DSTL): dstLowQ <= hwdata[15:0];
				30'(`DMACH_IDX_DSTH): dstHighQ <= hwdata[15:0];
				30'(`DMACH_IDX_THR): thrQ <= hwdata[15:0];
				30'(`DMACH_IDX_LEN): lenQ <= hwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// control: software write wins over the hardware enable clear
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrlQ <= `DMACH_RST16;
		end else if (ctrlWrite) begin
			ctrlQ <= hwdata[15:0] & `DMACH_CTRL_MASK;
		end else if (finish && !keepOn) begin
			ctrlQ[`DMACH_ON] <= 1'b0;
		end
	end

	// item index: counts items, zero at end or when disabled
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			idxQ <= `DMACH_RST16;
		end else if (!chanOn) begin
			idxQ <= `DMACH_RST16;
		end else if (finish) begin
			idxQ <= `DMACH_RST16;
		end else if (itemDone) begin
			idxQ <= idxNext;
		end
	end

	// interrupt pulse after the item whose index equals thrQ, when enabled, in the same cycle the index steps
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			chanIrq <= 1'b0;
		end else begin
			chanIrq <= itemDone && (thrQ == idxQ) &&
				ctrlQ[`DMACH_IRQEN];
		end
	end

	// fetched item held for the store
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dataQ <= `DMACH_RST32;
		end else if ((stateQ == dmach_pkg::ST_READ) && memReady) begin
			dataQ <= memRdata;
		end
	end

	// bus master address, direction and size for the next cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			memAddr <= `DMACH_RST32;
			memWrite <= 1'b0;
			memSize <= 2'h0;
			memWdata <= `DMACH_RST32;
		end else begin
			memSize <= ctrlQ[`DMACH_BW_HI:`DMACH_BW_LO];
			memWdata <= dataQ;
			case (stateQ)
				dmach_pkg::ST_WAIT: begin
					if (fillMode && idxQ != 16'h0000) begin
						memAddr <= dstCur;
						memWrite <= 1'b1;
					end else begin
						memAddr <= srcCur;
						memWrite <= 1'b0;
					end
				end
				dmach_pkg::ST_READ: begin
					if (memReady) begin
						memAddr <= dstCur;
						memWrite <= 1'b1;
						memWdata <= memRdata;
					end
				end
				dmach_pkg::ST_WRITE: begin
					if (memReady && fillMode) begin
						memAddr <= dstNext;
						memWrite <= 1'b1;
					end else if (memReady) begin
						memAddr <= srcNext;
						memWrite <= 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// channel sequencer
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			stateQ <= dmach_pkg::ST_IDLE;
		end else begin
			case (stateQ)
				dmach_pkg::ST_IDLE: begin
					if (chanOn && (!reqMode || reqSeen)) begin
						stateQ <= dmach_pkg::ST_WAIT;
					end
				end
				dmach_pkg::ST_WAIT: begin
					if (!chanOn) begin
						stateQ <= dmach_pkg::ST_IDLE;
					end else if (busGrant && fillMode &&
						idxQ != 16'h0000) begin
						stateQ <= dmach_pkg::ST_WRITE;
					end else if (busGrant) begin
						stateQ <= dmach_pkg::ST_READ;
					end
				end
				dmach_pkg::ST_READ: begin
					if (memReady && !chanOn) begin
						stateQ <= dmach_pkg::ST_IDLE;
					end else if (memReady) begin
						stateQ <= dmach_pkg::ST_WRITE;
					end
				end
				dmach_pkg::ST_WRITE: begin
					if (memReady) begin
						if (finish || !chanOn || reqMode) begin
							stateQ <= dmach_pkg::ST_IDLE;
						end else if (yieldMode) begin
							stateQ <= dmach_pkg::ST_GAP;
						end else if (fillMode) begin
							stateQ <= dmach_pkg::ST_WRITE;
						end else begin
							stateQ <= dmach_pkg::ST_READ;
						end
					end
				end
				dmach_pkg::ST_GAP: begin
					stateQ <= chanOn ? dmach_pkg::ST_WAIT :
						dmach_pkg::ST_IDLE;
				end
				default: begin
					stateQ <= dmach_pkg::ST_IDLE;
				end
			endcase
		end
	end

endmodule

// File: logic/dmach_map.svh
// register offsets, control field positions and reset values of the channel
`ifndef DMACH_MAP_SVH
`define DMACH_MAP_SVH

// register indices; the byte address is four times the index
`define DMACH_IDX_ITEM 32'h5000352E
`define DMACH_IDX_SRCL 32'h50003530
`define DMACH_IDX_SRCH 32'h50003532
`define DMACH_IDX_DSTL 32'h50003534
`define DMACH_IDX_DSTH 32'h50003536
`define DMACH_IDX_THR 32'h50003538
`define DMACH_IDX_LEN 32'h5000353A
`define DMACH_IDX_CTRL 32'h5000353C

// control field positions
`define DMACH_ON 0
`define DMACH_BW_LO 1
`define DMACH_BW_HI 2
`define DMACH_IRQEN 3
`define DMACH_REQMODE 4
`define DMACH_DINC 5
`define DMACH_SINC 6
`define DMACH_CIRC 7
`define DMACH_PRIO_LO 8
`define DMACH_PRIO_HI 10
`define DMACH_YIELD 11
`define DMACH_FILL 12
`define DMACH_SENSE 13

// writable control bits, reserved bits read zero
`define DMACH_CTRL_MASK 16'h3FFF
`define DMACH_RST16 16'h0000
`define DMACH_RST32 32'h00000000

`endif

// File: logic/dmach_pkg.sv
// types shared by the channel logic
package dmach_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT,
		ST_READ,
		ST_WRITE,
		ST_GAP
	} dmach_state_t;
	typedef logic [15:0] dmach_half_t;
endpackage

// File: verification/dmach_monitor.sv
// port checker for the dma channel, bound to the channel
`timescale 1ns/10ps
module dmach_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// arbitration and bus master port
	input wire logic busReq,
	input wire logic busGrant,
	input wire logic busLock,
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic memReady,
	// status
	input wire logic chanIrq,
	input wire logic chanActive
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// a store that completes on the system bus
	sequence s_store;
		memReq && memWrite && memReady;
	endsequence
	// a fetch that completes on the system bus
	sequence s_fetch;
		memReq && !memWrite && memReady;
	endsequence
	property p_idle;
		!chanActive |-> !busReq && !memReq;
	endproperty
	property p_lock;
		busLock |-> busReq;
	endproperty
	property p_hold;
		memReq && !memReady |=> memReq && $stable(memWrite);
	endproperty
	property p_pair;
		s_fetch |=> memReq && memWrite;
	endproperty
	property p_gnt;
		$rose(memReq) |-> $past(busGrant);
	endproperty
	property p_irq;
		chanIrq |-> $past(memReq && memWrite && memReady);
	endproperty
	property p_pulse;
		s_store ##1 chanIrq |=> !chanIrq;
	endproperty
	property p_yield;
		s_store ##0 !busLock |=> !busReq && !memReq;
	endproperty
	a_idle: assert property (p_idle) else $error("bus used while idle");
	a_lock: assert property (p_lock) else $error("lock without request");
	a_hold: assert property (p_hold) else $error("cycle dropped early");
	a_pair: assert property (p_pair) else $error("fetch without store");
	a_gnt: assert property (p_gnt) else $error("cycle without grant");
	a_irq: assert property (p_irq) else $error("irq without store");
	a_pulse: assert property (p_pulse) else $error("irq too long");
	a_yield: assert property (p_yield) else $error("no gap cycle");
endmodule

bind dmach_channel dmach_monitor u_mon (
	.sys_clk(sys_clk), .rst_b(rst_b), .busReq(busReq),
	.busGrant(busGrant), .busLock(busLock), .memReq(memReq),
	.memWrite(memWrite), .memReady(memReady), .chanIrq(chanIrq),
	.chanActive(chanActive)
);

// File: verification/dmach_mem_model.sv
// system memory model with wait states and a transfer log
`timescale 1ns/10ps
module dmach_mem_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// channel master port
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic [31:0] memAddr,
	input wire logic [31:0] memWdata,
	output logic [31:0] memRdata,
	output logic memReady,
	// wait states and log
	input wire logic [1:0] slow,
	output logic [15:0] wrCount_q,
	output logic [15:0] rdCount_q,
	output logic [31:0] lastWa_q,
	output logic [31:0] lastWd_q
);
	logic [1:0] wait_q;
	logic [31:0] tog_q;
	// a cycle completes once its wait states have run out
	assign memReady = memReq && wait_q == 2'h0;
	// data off the bus is the inverted address during a fetch, else a pattern that changes every cycle
	assign memRdata = (memReq && !memWrite) ? ~memAddr : tog_q;
	// wait state counter, reloaded after each cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			wait_q <= 2'h0;
		else if (memReady)
			wait_q <= slow;
		else if (memReq && wait_q != 2'h0)
			wait_q <= wait_q - 2'h1;
	end
	// filler pattern and transfer log
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tog_q <= 32'h5A5A5A5A;
			wrCount_q <= 16'h0000;
			rdCount_q <= 16'h0000;
			lastWa_q <= 32'h00000000;
			lastWd_q <= 32'h00000000;
		end else begin
			tog_q <= ~tog_q + 32'h00000001;
			if (memReady && memWrite) begin
				wrCount_q <= wrCount_q + 16'h0001;
				lastWa_q <= memAddr;
				lastWd_q <= memWdata;
			end
			if (memReady && !memWrite)
				rdCount_q <= rdCount_q + 16'h0001;
		end
	end
endmodule

// File: verification/tb.sv
// self-checking bench for the dma channel
`timescale 1ns/10ps
`include "dmach_map.svh"
module tb;
	typedef struct {
		logic [15:0] ctrl, len, thr;
		logic [1:0] slow;
		logic [15:0] wn, rn, irq;
		logic [31:0] wa, wd;
	} dmach_row_t;
	localparam logic [31:0] SRC = 32'h10000100;
	localparam logic [31:0] DST = 32'h20000200;
	// control, length, threshold, waits, stores, fetches, irqs, last store
	dmach_row_t rows [5] = '{
		'{16'h076D, 16'h3, 16'h2, 2'h0, 16'h4, 16'h4, 16'h1,
			32'h2000020C, 32'hEFFFFEF3},
		'{16'h084B, 16'h2, 16'h5, 2'h2, 16'h3, 16'h3, 16'h0,
			32'h20000200, 32'hEFFFFEFB},
		'{16'h0021, 16'h0, 16'h0, 2'h1, 16'h1, 16'h1, 16'h0,
			32'h20000200, 32'hEFFFFEFF},
		'{16'h106D, 16'h2, 16'h0, 2'h0, 16'h3, 16'h1, 16'h1,
			32'h20000208, 32'hEFFFFEFF},
		'{16'h0061, 16'h2, 16'h1, 2'h1, 16'h3, 16'h3, 16'h0,
			32'h20000202, 32'hEFFFFEFD}};
	logic [31:0] regIdx [8] = '{`DMACH_IDX_ITEM, `DMACH_IDX_SRCL,
		`DMACH_IDX_SRCH, `DMACH_IDX_DSTL, `DMACH_IDX_DSTH,
		`DMACH_IDX_THR, `DMACH_IDX_LEN, `DMACH_IDX_CTRL};
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, busGrant = 1'b0, periphReq = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic [1:0] htrans = 2'h0, slow = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, busReq, busLock, memReq, memWrite;
	logic memReady, chanIrq, chanActive;
	logic [31:0] hrdata, memAddr, memWdata, memRdata, lastWa_q, lastWd_q;
	logic [1:0] memSize;
	logic [2:0] chanPriority, chanNumber;
	logic [15:0] wrCount_q, rdCount_q, w0, r0, i0;
	logic [15:0] irqs = 16'h0;
	logic [15:0] locks = 16'h0, l0;
	int failCount = 0, compares = 0, cyc = 0;

	dmach_channel u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .busReq(busReq),
		.busGrant(busGrant), .busLock(busLock),
		.chanPriority(chanPriority), .chanNumber(chanNumber),
		.memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
		.memSize(memSize), .memWdata(memWdata), .memRdata(memRdata),
		.memReady(memReady), .periphReq(periphReq), .chanIrq(chanIrq),
		.chanActive(chanActive));
	dmach_mem_model u_mem (.sys_clk(sys_clk), .rst_b(rst_b),
		.memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
		.memWdata(memWdata), .memRdata(memRdata), .memReady(memReady),
		.slow(slow), .wrCount_q(wrCount_q), .rdCount_q(rdCount_q),
		.lastWa_q(lastWa_q), .lastWd_q(lastWd_q));

	// clock, grant that follows the request, irq counter, hang guard
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		busGrant <= busReq;
		if (chanIrq === 1'b1)
			irqs <= irqs + 16'h1;
		if (busLock === 1'b1)
			locks <= locks + 16'h1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failCount++;
			testDone();
		end
	end

	// verdict and end of run
	task testDone();
		$display("comparisons %0d mismatches %0d", compares, failCount);
		if (failCount == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failCount++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one single AHB-Lite word transfer
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task wr(input logic [31:0] idx, input logic [15:0] d);
		ahb(1'b1, idx << 2, {16'h0000, d});
	endtask
	task rdchk(input logic [31:0] idx, input logic [15:0] exp);
		ahb(1'b0, idx << 2, 32'h0);
		chk(rd, {16'h0000, exp});
	endtask
	task waitIdle();
		repeat (4) @(posedge sys_clk);
		while (chanActive !== 1'b0) @(posedge sys_clk);
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		// reset values, read-only index, unmapped place
		foreach (regIdx[k]) rdchk(regIdx[k], 16'h0000);
		wr(`DMACH_IDX_ITEM, 16'h1234);
		rdchk(`DMACH_IDX_ITEM, 16'h0000);
		wr(32'h50003600, 16'hBEEF);
		rdchk(32'h50003600, 16'h0000);
		chk(hresp, 32'h0);
		chk(chanNumber, 32'h0);
		$display("reset test done");
		for (int i = 0; i < 5; i++) begin
			slow <= rows[i].slow;
			w0 = wrCount_q;
			l0 = locks;
			r0 = rdCount_q;
			i0 = irqs;
			wr(`DMACH_IDX_SRCL, SRC[15:0]);
			wr(`DMACH_IDX_SRCH, SRC[31:16]);
			wr(`DMACH_IDX_DSTL, DST[15:0]);
			wr(`DMACH_IDX_DSTH, DST[31:16]);
			wr(`DMACH_IDX_THR, rows[i].thr);
			wr(`DMACH_IDX_LEN, rows[i].len);
			wr(`DMACH_IDX_CTRL, rows[i].ctrl);
			waitIdle();
			chk(wrCount_q - w0, rows[i].wn);
			chk(rdCount_q - r0, rows[i].rn);
			chk(irqs - i0, rows[i].irq);
			chk(lastWa_q, rows[i].wa);
			chk(lastWd_q, rows[i].wd);
			chk(chanPriority, rows[i].ctrl[10:8]);
			chk(memSize, rows[i].ctrl[2:1]);
			chk(locks != l0, !rows[i].ctrl[11] || rows[i].ctrl[12]);
			rdchk(`DMACH_IDX_CTRL, rows[i].ctrl & 16'hFFFE);
			rdchk(`DMACH_IDX_ITEM, 16'h0000);
			$display("row %0d done", i);
		end
		// circular level requests, then enable cleared mid-run
		w0 = wrCount_q;
		wr(`DMACH_IDX_LEN, 16'h0001);
		wr(`DMACH_IDX_CTRL, 16'h00F5);
		repeat (20) @(posedge sys_clk);
		chk(wrCount_q - w0, 32'h0);
		periphReq <= 1'b1;
		while (wrCount_q - w0 < 16'h3) @(posedge sys_clk);
		rdchk(`DMACH_IDX_CTRL, 16'h00F5);
		while (memReq !== 1'b1) @(posedge sys_clk);
		wr(`DMACH_IDX_CTRL, 16'h0000);
		periphReq <= 1'b0;
		repeat (10) @(posedge sys_clk);
		chk(chanActive, 32'h0);
		rdchk(`DMACH_IDX_ITEM, 16'h0000);
		$display("circular test done");
		// rising-edge requests: a held level moves one item only
		w0 = wrCount_q;
		wr(`DMACH_IDX_CTRL, 16'h2035);
		periphReq <= 1'b1;
		repeat (60) @(posedge sys_clk);
		chk(wrCount_q - w0, 32'h1);
		periphReq <= 1'b0;
		repeat (5) @(posedge sys_clk);
		periphReq <= 1'b1;
		repeat (40) @(posedge sys_clk);
		chk(wrCount_q - w0, 32'h2);
		rdchk(`DMACH_IDX_CTRL, 16'h2034);
		$display("edge test done");
		testDone();
	end
endmodule
